//--- core/als_regs.vh
// register offsets, field positions, reset values and timing counts of the axis supervisor
// Function
// - ready dropping while drive enabled reports code C0 and stops axis.
// - ready check ignored for digital servo or auxiliary axis.
// - moving positive, actual position wraps from high bound to low bound.
// - moving negative, actual position wraps from low bound to high bound.
// - enabled travel limits: target above upper limit errors and inhibits motion.
// - enabled travel limits: target below lower limit errors and inhibits motion.
// - travel limits skip follower master motion and move-at-velocity commands.
// - one enable bit gates both travel limits; default disabled.
// - upper limit above high bound is replaced by high bound, code 17.
// - lower limit below low bound is replaced by low bound, code 17.
// - travel limits bypassed for jog when position valid is off.
// - auxiliary with limits: program and jog stop; velocity moves wrap at 32-bit extremes.
// - auxiliary without limits: commanded position wraps at travel limit values.
// - summed velocity over limit reports F2 and is clamped to limit.
// - unidirectional mode withholds commands of opposite direction.
// - digital servo: normal means counterclockwise positive, reverse clockwise.
// - analog servo: normal means A leads B positive, reverse B leads A.
// - digital absolute feedback reports battery alarms; incremental suppresses them.
// - direction reversal inserts the backlash compensation distance.
// - compensation added before positive move, removed on negative; default zero.
// - backlash compensation unavailable when follower loop enabled.
`ifndef ALS_REGS_VH
`define ALS_REGS_VH
// register byte offsets
`define ALS_CTRL_OFS 8'h00
`define ALS_HIPOS_OFS 8'h04
`define ALS_LOPOS_OFS 8'h08
`define ALS_HITRV_OFS 8'h0C
`define ALS_LOTRV_OFS 8'h10
`define ALS_VLIM_OFS 8'h14
`define ALS_BKLSH_OFS 8'h18
`define ALS_CMD_OFS 8'h1C
`define ALS_VEL_OFS 8'h20
`define ALS_STAT_OFS 8'h24
`define ALS_ACTPOS_OFS 8'h28
`define ALS_CMDPOS_OFS 8'h2C
`define ALS_SRVCMD_OFS 8'h30
// control field positions
`define ALS_CTL_RDYEN 0
`define ALS_CTL_DIGITAL 1
`define ALS_CTL_AUX 2
`define ALS_CTL_TRVEN 3
`define ALS_CTL_FOLLOW 4
`define ALS_CTL_POSONLY 5
`define ALS_CTL_NEGONLY 6
`define ALS_CTL_REVERSE 7
`define ALS_CTL_ABSFB 8
`define ALS_CTL_ENABLE 9
`define ALS_CTL_POSVALID 10
`define ALS_CTL_CLRERR 11
// command field: kind in bits 1:0
`define ALS_KIND_PROG 2'h0
`define ALS_KIND_JOG 2'h1
`define ALS_KIND_MAV 2'h2
`define ALS_KIND_MASTER 2'h3
// reset values
`define ALS_CTRL_RST 32'h00000000
`define ALS_HIPOS_RST 32'h007FFFFF
`define ALS_LOPOS_RST 32'hFF800000
`define ALS_HITRV_RST 32'h007FFFFF
`define ALS_LOTRV_RST 32'hFF800000
`define ALS_VLIM_RST 32'h000F4240
`define ALS_BKLSH_RST 32'h00000000
`define ALS_AUX_MAX 32'h7FFFFFFF
`define ALS_AUX_MIN 32'h80000000
// error codes
`define ALS_ERR_RDY 8'hC0
`define ALS_ERR_ADJ 8'h17
`define ALS_ERR_VEL 8'hF2
`define ALS_ERR_TRV 8'h20
// timing: 50 MHz clock, 2 ms sample, 1 s ready window
`define ALS_CLK_HZ 50000000
`define ALS_SAMPLE_US 2000
`define ALS_RDY_MS 1000
`define ALS_SAMPLE_CYC (`ALS_CLK_HZ / 1000000 * `ALS_SAMPLE_US)
`define ALS_RDY_CYC (`ALS_CLK_HZ / 1000 * `ALS_RDY_MS)
`endif

//--- core/als_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module als_sync #(
   parameter W = 1
) (
   input wire hclk,
   input wire hresetn,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_r;
   // ======================================
   // two stages, first read only by second
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

//--- core/als_axis_sup.v
// axis limit and direction supervisor with AHB-Lite register slave
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`include "als_regs.vh"
// ======================================
// register map, byte offsets on haddr[7:0]
// 00 control, read and write
// 04 high position bound, actual position wraps here
// 08 low position bound
// 0C upper travel limit, reads back the clamped value
// 10 lower travel limit, reads back the clamped value
// 14 velocity limit on the summed command
// 18 backlash compensation distance
// 1C command kind, a write arms one limit check
// 20 summed signed velocity per sample
// 24 status, read only
// 28 actual position, read only
// 2C commanded position, read only
// 30 programmed target position
// unmapped offsets ignore writes and read as zero
// ======================================
// control bits
// 0 drive ready check, analog servo only
// 1 digital servo
// 2 auxiliary axis
// 3 travel limit enable
// 4 follower loop enable
// 5 positive only
// 6 negative only
// 7 reverse axis direction
// 8 absolute feedback
// 9 enable drive
// 10 position valid
// 11 clear errors, self clearing
// ======================================
// status bits
// 0 any error latched
// 1 drive enabled and ready seen, or enabled with the ready check off
// 2 axis stopped by a ready fault
// 3 motion inhibited by a travel target error
// 4 travel limit adjusted to a position bound
// 5 velocity clamped
// 6 battery alarm
// 15:8 last error code
// ======================================
// hazards
// the ready check runs on the sample, so a drop that starts and ends between two samples is missed
// a set in the sample cycle wins over a clear in that same cycle
// backlash is applied once, on the first sample after a reversal
// velocity moves see the travel limits only as wrap points, on an auxiliary axis with travel limits disabled
module als_axis_sup #(
   parameter SAMPLE_CYC = `ALS_SAMPLE_CYC,
   parameter RDY_CYC = `ALS_RDY_CYC
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire drive_ready_faceplate_input,
   input wire enc_a,
   input wire enc_b,
   input wire battery_alarm_in,
   output reg drive_enable,
   output reg [31:0] servo_cmd,
   output reg axis_stopped,
   output reg battery_alarm,
   output reg sample_tick
);
   // ======================================
   // registers and state
   reg [31:0] ctrl_r;
   reg [31:0] hipos_r;
   reg [31:0] lopos_r;
   reg [31:0] hitrv_r;
   reg [31:0] lotrv_r;
   reg [31:0] vlim_r;
   reg [31:0] bklsh_r;
   reg [31:0] cmd_tgt_r;
   reg [1:0] cmd_kind_r;
   reg cmd_pend_r;
   reg [31:0] vel_r;
   reg [7:0] err_code_r;
   reg err_r;
   reg inhibit_r;
   reg adj_r;
   reg vel_err_r;
   reg [31:0] act_pos_r;
   reg [31:0] cmd_pos_r;
   reg last_dir_r;
   reg moved_r;
   reg [31:0] samp_cnt_r;
   reg [31:0] rdy_cnt_r;
   reg drv_enabled_r;
   reg [1:0] enc_prev_r;
   reg wr_pend_r;
   reg [7:0] wr_addr_r;
   reg rd_pend_r;
   reg [7:0] rd_addr_r;
   wire rdy_s;
   wire enc_a_s;
   wire enc_b_s;
   wire batt_s;
   // ======================================
   // pin synchronisers
   als_sync #(.W(4)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({drive_ready_faceplate_input, enc_a, enc_b, battery_alarm_in}),
      .q({rdy_s, enc_a_s, enc_b_s, batt_s})
   );
   // ======================================
   // bus slave: zero wait, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   wire bus_go = hsel & htrans[1] & hready;
   wire digital = ctrl_r[`ALS_CTL_DIGITAL];
   wire aux = ctrl_r[`ALS_CTL_AUX];
   wire follow = ctrl_r[`ALS_CTL_FOLLOW];
   wire rdy_chk = ctrl_r[`ALS_CTL_RDYEN] & ~digital & ~aux;
   wire trv_en = ctrl_r[`ALS_CTL_TRVEN];
   // ======================================
   // effective travel limits clamped to position bounds
   wire hi_over = trv_en & ~aux & ($signed(hitrv_r) > $signed(hipos_r));
   wire lo_under = trv_en & ~aux & ($signed(lotrv_r) < $signed(lopos_r));
   wire [31:0] hi_eff = hi_over ? hipos_r : hitrv_r;
   wire [31:0] lo_eff = lo_under ? lopos_r : lotrv_r;
   // ======================================
   // limit check applies to program and jog only
   wire is_jog = (cmd_kind_r == `ALS_KIND_JOG);
   wire lim_apply = trv_en & ((cmd_kind_r == `ALS_KIND_PROG) | is_jog)
      & ~(is_jog & ~ctrl_r[`ALS_CTL_POSVALID]);
   wire tgt_hi = lim_apply & ($signed(cmd_tgt_r) > $signed(hi_eff));
   wire tgt_lo = lim_apply & ($signed(cmd_tgt_r) < $signed(lo_eff));
   // ======================================
   // velocity sum, clamp, direction gating
   wire [31:0] vel_abs = vel_r[31] ? (32'h00000000 - vel_r) : vel_r;
   wire vel_over = ($signed(vel_abs) > $signed(vlim_r)) | (vel_r == 32'h80000000);
   wire [31:0] vel_clip = vel_over ? (vel_r[31] ? (32'h00000000 - vlim_r) : vlim_r)
      : vel_r;
   wire dir_blk = (ctrl_r[`ALS_CTL_POSONLY] & vel_clip[31])
      | (ctrl_r[`ALS_CTL_NEGONLY] & ~vel_clip[31] & (vel_clip != 32'h00000000));
   wire [31:0] vel_ok = dir_blk ? 32'h00000000 : vel_clip;
   // backlash: add on reversal to positive, remove on reversal to negative
   wire new_dir = vel_ok[31];
   wire rev = moved_r & (vel_ok != 32'h00000000) & (new_dir != last_dir_r)
      & ~follow;
   wire [31:0] bk_add = rev ? (new_dir ? (32'h00000000 - bklsh_r) : bklsh_r)
      : 32'h00000000;
   wire [31:0] step = vel_ok + bk_add;
   // ======================================
   // commanded position wrap bounds
   wire [31:0] cp_hi = aux ? (trv_en ? `ALS_AUX_MAX : hitrv_r) : hipos_r;
   wire [31:0] cp_lo = aux ? (trv_en ? `ALS_AUX_MIN : lotrv_r) : lopos_r;
   wire [32:0] cp_sum = {cmd_pos_r[31], cmd_pos_r} + {step[31], step};
   wire [31:0] cp_raw = cp_sum[31:0];
   wire cp_ovf = cp_sum[32] ^ cp_sum[31];
   reg [31:0] cp_next;
   // aux limits enabled stop program and jog at limits
   wire aux_stop = aux & trv_en & (cmd_kind_r != `ALS_KIND_MAV) &
      ((~step[31] & ($signed(cp_raw) > $signed(hitrv_r)))
      | (step[31] & ($signed(cp_raw) < $signed(lotrv_r))));
   // ======================================
   // commanded position wrap logic
   always @* begin
      cp_next = cp_raw;
      if (aux_stop) begin
         cp_next = step[31] ? lotrv_r : hitrv_r;
      end else if (~step[31] & (cp_ovf | ($signed(cp_raw) > $signed(cp_hi)))) begin
         cp_next = cp_lo;
      end else if (step[31] & (cp_ovf | ($signed(cp_raw) < $signed(cp_lo)))) begin
         cp_next = cp_hi;
      end
   end
   // ======================================
   // encoder decode with axis direction
   wire [1:0] enc_now = {enc_a_s, enc_b_s};
   wire enc_step = (enc_now != enc_prev_r) & (enc_now[0] ^ enc_prev_r[1]);
   wire enc_move = (enc_now != enc_prev_r) & (enc_now != ~enc_prev_r);
   // a leading b when new a differs from old b pattern
   wire a_lead = enc_move & ~enc_step;
   wire enc_pos = a_lead ^ ctrl_r[`ALS_CTL_REVERSE];
   wire [31:0] ap_next = enc_pos ?
      ((act_pos_r == hipos_r) ? lopos_r : act_pos_r + 32'h00000001)
      : ((act_pos_r == lopos_r) ? hipos_r : act_pos_r - 32'h00000001);
   // ======================================
   // bus write, register and supervision process
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= `ALS_CTRL_RST;
         hipos_r <= `ALS_HIPOS_RST;
         lopos_r <= `ALS_LOPOS_RST;
         hitrv_r <= `ALS_HITRV_RST;
         lotrv_r <= `ALS_LOTRV_RST;
         vlim_r <= `ALS_VLIM_RST;
         bklsh_r <= `ALS_BKLSH_RST;
         cmd_tgt_r <= 32'h00000000;
         cmd_kind_r <= 2'h0;
         cmd_pend_r <= 1'b0;
         vel_r <= 32'h00000000;
         err_code_r <= 8'h00;
         err_r <= 1'b0;
         inhibit_r <= 1'b0;
         adj_r <= 1'b0;
         vel_err_r <= 1'b0;
         act_pos_r <= 32'h00000000;
         cmd_pos_r <= 32'h00000000;
         last_dir_r <= 1'b0;
         moved_r <= 1'b0;
         samp_cnt_r <= 32'h00000000;
         rdy_cnt_r <= 32'h00000000;
         drv_enabled_r <= 1'b0;
         enc_prev_r <= 2'h0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rd_pend_r <= 1'b0;
         rd_addr_r <= 8'h00;
         drive_enable <= 1'b0;
         servo_cmd <= 32'h00000000;
         axis_stopped <= 1'b0;
         battery_alarm <= 1'b0;
         sample_tick <= 1'b0;
      end else begin
         // address phase capture
         wr_pend_r <= bus_go & hwrite;
         rd_pend_r <= bus_go & ~hwrite;
         if (bus_go) begin
            wr_addr_r <= haddr[7:0];
            rd_addr_r <= haddr[7:0];
         end
         ctrl_r[`ALS_CTL_CLRERR] <= 1'b0;
         if (wr_pend_r) begin
            case (wr_addr_r)
               `ALS_CTRL_OFS: ctrl_r <= hwdata;
               `ALS_HIPOS_OFS: hipos_r <= hwdata;
               `ALS_LOPOS_OFS: lopos_r <= hwdata;
               `ALS_HITRV_OFS: hitrv_r <= hwdata;
               `ALS_LOTRV_OFS: lotrv_r <= hwdata;
               `ALS_VLIM_OFS: vlim_r <= hwdata;
               `ALS_BKLSH_OFS: bklsh_r <= hwdata;
               `ALS_CMD_OFS: begin
                  cmd_kind_r <= hwdata[1:0];
                  cmd_pend_r <= 1'b1;
               end
               `ALS_VEL_OFS: vel_r <= hwdata;
               `ALS_SRVCMD_OFS: cmd_tgt_r <= hwdata;
               default: ;
            endcase
         end
         // encoder tracks actual position every clock
         enc_prev_r <= enc_now;
         if (enc_move) begin
            act_pos_r <= ap_next;
         end
         // sample divider enable
         sample_tick <= 1'b0;
         if (samp_cnt_r >= SAMPLE_CYC - 1) begin
            samp_cnt_r <= 32'h00000000;
            sample_tick <= 1'b1;
         end else begin
            samp_cnt_r <= samp_cnt_r + 32'h00000001;
         end
         drive_enable <= ctrl_r[`ALS_CTL_ENABLE];
         // drive-ready window after enable command
         if (!ctrl_r[`ALS_CTL_ENABLE]) begin
            rdy_cnt_r <= 32'h00000000;
            drv_enabled_r <= 1'b0;
         end else if (rdy_s | ~rdy_chk) begin
            drv_enabled_r <= 1'b1;
         end else if (rdy_cnt_r < RDY_CYC) begin
            rdy_cnt_r <= rdy_cnt_r + 32'h00000001;
         end
         battery_alarm <= digital & ctrl_r[`ALS_CTL_ABSFB] & batt_s;
         // once per sample period, set wins over clear
         if (ctrl_r[`ALS_CTL_CLRERR]) begin
            err_r <= 1'b0;
            err_code_r <= 8'h00;
            inhibit_r <= 1'b0;
            axis_stopped <= 1'b0;
            adj_r <= 1'b0;
            vel_err_r <= 1'b0;
         end
         if (sample_tick) begin
            if (rdy_chk & ctrl_r[`ALS_CTL_ENABLE]
               & ((drv_enabled_r & ~rdy_s) | (rdy_cnt_r >= RDY_CYC))) begin
               err_r <= 1'b1;
               err_code_r <= `ALS_ERR_RDY;
               axis_stopped <= 1'b1;
            end else if (cmd_pend_r & (tgt_hi | tgt_lo)) begin
               err_r <= 1'b1;
               err_code_r <= `ALS_ERR_TRV;
               inhibit_r <= 1'b1;
            end else if (hi_over | lo_under) begin
               adj_r <= 1'b1;
               err_r <= 1'b1;
               err_code_r <= `ALS_ERR_ADJ;
            end else if (vel_over) begin
               vel_err_r <= 1'b1;
               err_r <= 1'b1;
               err_code_r <= `ALS_ERR_VEL;
            end
            // a command written in this very cycle stays armed
            if (!(wr_pend_r & (wr_addr_r == `ALS_CMD_OFS))) begin
               cmd_pend_r <= 1'b0;
            end
            if (axis_stopped | inhibit_r | ~drive_enable | (cmd_pend_r & (tgt_hi | tgt_lo))) begin
               servo_cmd <= 32'h00000000;
            end else begin
               servo_cmd <= step;
               cmd_pos_r <= cp_next;
               if (vel_ok != 32'h00000000) begin
                  last_dir_r <= new_dir;
                  moved_r <= 1'b1;
               end
            end
         end
      end
   end
   // ======================================
   // read data phase
   always @* begin
      hrdata = 32'h00000000;
      if (rd_pend_r) begin
         case (rd_addr_r)
            `ALS_CTRL_OFS: hrdata = ctrl_r;
            `ALS_HIPOS_OFS: hrdata = hipos_r;
            `ALS_LOPOS_OFS: hrdata = lopos_r;
            `ALS_HITRV_OFS: hrdata = hi_eff;
            `ALS_LOTRV_OFS: hrdata = lo_eff;
            `ALS_VLIM_OFS: hrdata = vlim_r;
            `ALS_BKLSH_OFS: hrdata = bklsh_r;
            `ALS_CMD_OFS: hrdata = {29'h0, cmd_pend_r, cmd_kind_r};
            `ALS_VEL_OFS: hrdata = vel_r;
            `ALS_STAT_OFS: hrdata = {16'h0, err_code_r, 1'b0, battery_alarm, vel_err_r,
               adj_r, inhibit_r, axis_stopped, drv_enabled_r, err_r};
            `ALS_ACTPOS_OFS: hrdata = act_pos_r;
            `ALS_CMDPOS_OFS: hrdata = cmd_pos_r;
            `ALS_SRVCMD_OFS: hrdata = cmd_tgt_r;
            default: hrdata = 32'h00000000;
         endcase
      end
   end
endmodule

//--- test/als_axis_sup_asserts.sv
// port checker for the axis supervisor
`timescale 1ns/10ps
module als_chk #(
   parameter SAMPLE_CYC = 10,
   parameter RDY_CYC = 50
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire drive_enable,
   input wire [31:0] servo_cmd,
   input wire axis_stopped,
   input wire battery_alarm_in,
   input wire battery_alarm,
   input wire sample_tick
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ====================================
   // helpers: tick spacing and bus data phases
   reg [31:0] gap_r;
   reg seen_r;
   reg rd_dp_r;
   reg ctl_dp_r;
   wire clr_now = ctl_dp_r & hwdata[11];
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_r <= 32'h0;
         seen_r <= 1'b0;
         rd_dp_r <= 1'b0;
         ctl_dp_r <= 1'b0;
      end else begin
         gap_r <= sample_tick ? 32'h0 : gap_r + 32'h1;
         seen_r <= seen_r | sample_tick;
         rd_dp_r <= hsel & htrans[1] & hready & !hwrite;
         ctl_dp_r <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == 8'h00);
      end
   end
   // ====================================
   // assertions
   chk_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus answer not zero wait okay");
   chk_tick_period: assert property (sample_tick && seen_r |-> gap_r == SAMPLE_CYC - 1)
      else $error("sample tick spacing wrong");
   chk_tick_single: assert property (sample_tick |=> !sample_tick [*8])
      else $error("sample tick longer than one cycle");
   chk_rdata_idle: assert property (!rd_dp_r |-> hrdata == 32'h0)
      else $error("read data outside read data phase");
   chk_stop_tick: assert property ($rose(axis_stopped) |-> $past(sample_tick))
      else $error("axis stopped off a sample");
   chk_stop_enabled: assert property ($rose(axis_stopped) |-> $past(drive_enable))
      else $error("axis stopped while drive not enabled");
   chk_stop_clear: assert property ($fell(axis_stopped) |-> $past(clr_now, 2))
      else $error("stop released without clear");
   chk_cmd_tick: assert property (!$stable(servo_cmd) |-> $past(sample_tick))
      else $error("servo command moved off a sample");
   chk_batt_quiet: assert property (!battery_alarm_in [*4] |-> !battery_alarm)
      else $error("battery alarm without alarm input");
   cover property ($rose(axis_stopped));
   cover property ($fell(axis_stopped));
   cover property (battery_alarm);
endmodule

bind als_axis_sup als_chk #(.SAMPLE_CYC(SAMPLE_CYC), .RDY_CYC(RDY_CYC)) u_als_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .drive_enable(drive_enable),
   .servo_cmd(servo_cmd), .axis_stopped(axis_stopped),
   .battery_alarm_in(battery_alarm_in), .battery_alarm(battery_alarm),
   .sample_tick(sample_tick));

//--- test/als_amp.sv
// servo amplifier model: drive ready and quadrature encoder
`timescale 1ns/10ps
module als_amp (
   input wire hclk,
   input wire drive_enable,
   input wire drop_ready,
   output reg drive_ready_faceplate_input,
   output reg enc_a,
   output reg enc_b
);
   reg [5:0] dly_r = 6'h0;
   reg [1:0] ph = 2'h0;
   initial begin
      drive_ready_faceplate_input = 1'b0;
      enc_a = 1'b0;
      enc_b = 1'b0;
   end
   // ready 20 cycles after enable, well inside the window
   always @(posedge hclk) begin
      dly_r <= !drive_enable ? 6'h0 : (dly_r == 6'h14 ? dly_r : dly_r + 6'h1);
      drive_ready_faceplate_input <= (dly_r == 6'h14) & !drop_ready;
   end
   // one count per 4 cycles, a was ahead of b for positive counts
   task step(input integer n);
      integer i;
      for (i = 0; i < (n < 0 ? -n : n); i++) begin
         repeat (4) @(posedge hclk);
         ph = n > 0 ? ph + 2'h1 : ph - 2'h1;
         enc_a <= ph[1] ^ ph[0];
         enc_b <= ph[1];
      end
      repeat (8) @(posedge hclk);
   endtask
endmodule

//--- test/als_axis_sup_tb.sv
// self-checking testbench of the axis supervisor
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module als_axis_sup_tb;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg hsel = 1'b0;
   reg hwrite = 1'b0;
   reg drop = 1'b0;
   reg batt = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [31:0] hwdata = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg [2:0] hsize = 3'h2;
   reg [31:0] d;
   reg [31:0] tc [0:6] = '{32'h20A, 32'h20A, 32'h20A, 32'h21A, 32'h202, 32'h20A, 32'h60A};
   reg [31:0] tt [0:6] = '{32'h3E9, 32'hFFFFFC17, 32'h3E9, 32'h3E9, 32'h3E9, 32'h3E9, 32'h3E9};
   reg [1:0] tk [0:6] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h0, 2'h1, 2'h1};
   reg [6:0] te = 7'h43;
   wire [31:0] hrdata;
   wire [31:0] servo_cmd;
   wire hreadyout, hresp, rdy, ea, eb, den, stp, balm, tick;
   integer err_total = 0;
   integer n_compared = 0;
   integer i;
   always #10 hclk = ~hclk;
   als_axis_sup #(.SAMPLE_CYC(10), .RDY_CYC(50)) u_als_axis_sup (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .drive_ready_faceplate_input(rdy),
      .enc_a(ea), .enc_b(eb), .battery_alarm_in(batt), .drive_enable(den),
      .servo_cmd(servo_cmd), .axis_stopped(stp), .battery_alarm(balm), .sample_tick(tick));
   als_amp u_als_amp (.hclk(hclk), .drive_enable(den), .drop_ready(drop),
      .drive_ready_faceplate_input(rdy), .enc_a(ea), .enc_b(eb));
   // ====================================
   // bus and check tasks
   task bus(input w, input [7:0] a, input [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
   endtask
   task wr(input [7:0] a, input [31:0] v);
      bus(1'b1, a, v);
   endtask
   task rc(input [7:0] a, input [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK($sformatf("register %h", a), e, d)
   endtask
   task st(input [7:0] code);
      bus(1'b0, 8'h24, 32'h0);
      `CHK("status code", code, d[15:8])
      `CHK("error flag", code != 8'h00, d[0])
   endtask
   task ticks(input integer n);
      repeat (n) begin
         @(posedge hclk);
         while (tick !== 1'b1) @(posedge hclk);
      end
      @(posedge hclk);
   endtask
   task sc(input [31:0] e);
      `CHK("servo command", e, servo_cmd)
   endtask
   task clr(input [31:0] c);
      wr(8'h00, c | 32'h800);
   endtask
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ====================================
   // watchdog
   initial begin
      repeat (30000) @(posedge hclk);
      err_total++;
      tally_and_finish;
   end
   // ====================================
   // test sequence
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rc(8'h04, 32'h007FFFFF);
      rc(8'h08, 32'hFF800000);
      rc(8'h0C, 32'h007FFFFF);
      rc(8'h10, 32'hFF800000);
      rc(8'h14, 32'h000F4240);
      rc(8'h18, 32'h0);
      rc(8'h00, 32'h0);
      rc(8'h40, 32'h0);
      $display("test reset values done");
      wr(8'h04, 32'h2);
      wr(8'h08, 32'hFFFFFFFE);
      u_als_amp.step(3);
      rc(8'h28, 32'hFFFFFFFE);
      u_als_amp.step(-1);
      rc(8'h28, 32'h2);
      wr(8'h00, 32'h80);
      u_als_amp.step(1);
      rc(8'h28, 32'h1);
      wr(8'h04, 32'h007FFFFF);
      wr(8'h08, 32'hFF800000);
      $display("test encoder wrap done");
      wr(8'h00, 32'h201);
      ticks(8);
      st(8'h00);
      drop <= 1'b1;
      ticks(2);
      st(8'hC0);
      `CHK("axis stopped", 1'b1, stp)
      for (i = 0; i < 2; i++) begin
         clr(32'h0);
         wr(8'h00, i ? 32'h205 : 32'h203);
         ticks(8);
         st(8'h00);
      end
      clr(32'h0);
      drop <= 1'b0;
      $display("test drive ready done");
      wr(8'h00, 32'h202);
      wr(8'h20, 32'h001E8480);
      ticks(2);
      sc(32'h000F4240);
      st(8'hF2);
      wr(8'h20, 32'h5);
      clr(32'h202);
      wr(8'h18, 32'h3);
      wr(8'h20, 32'hFFFFFFFB);
      ticks(1);
      sc(32'hFFFFFFF8);
      ticks(1);
      sc(32'hFFFFFFFB);
      wr(8'h20, 32'h5);
      ticks(1);
      sc(32'h8);
      ticks(1);
      sc(32'h5);
      wr(8'h00, 32'h212);
      wr(8'h20, 32'hFFFFFFFB);
      ticks(1);
      sc(32'hFFFFFFFB);
      wr(8'h18, 32'h0);
      wr(8'h00, 32'h222);
      ticks(2);
      sc(32'h0);
      wr(8'h20, 32'h5);
      ticks(2);
      sc(32'h5);
      wr(8'h00, 32'h242);
      ticks(2);
      sc(32'h0);
      $display("test velocity done");
      wr(8'h00, 32'h20A);
      wr(8'h0C, 32'h00800000);
      ticks(2);
      rc(8'h0C, 32'h007FFFFF);
      st(8'h17);
      wr(8'h0C, 32'h3E8);
      clr(32'h20A);
      wr(8'h10, 32'hFF7FFFFF);
      ticks(2);
      rc(8'h10, 32'hFF800000);
      st(8'h17);
      wr(8'h0C, 32'h3E8);
      wr(8'h10, 32'hFFFFFC18);
      for (i = 0; i < 7; i++) begin
         clr(tc[i]);
         wr(8'h30, tt[i]);
         wr(8'h1C, {30'h0, tk[i]});
         ticks(2);
         st(te[i] ? 8'h20 : 8'h00);
      end
      clr(32'h0);
      wr(8'h0C, 32'h10);
      wr(8'h10, 32'h8);
      wr(8'h20, 32'h000F4240);
      clr(32'h204);
      ticks(2);
      rc(8'h2C, 32'h8);
      wr(8'h00, 32'h20C);
      ticks(2);
      rc(8'h2C, 32'h10);
      $display("test travel limits done");
      wr(8'h00, 32'h102);
      batt <= 1'b1;
      repeat (6) @(posedge hclk);
      `CHK("battery alarm", 1'b1, balm)
      wr(8'h00, 32'h002);
      repeat (6) @(posedge hclk);
      `CHK("battery alarm", 1'b0, balm)
      $display("test battery alarm done");
      tally_and_finish;
   end
endmodule
